// ### hw/mocs_defs.vh
`ifndef MOCS_DEFS_VH
`define MOCS_DEFS_VH

// Host word offsets
`define MOCS_ADDR_ANALOG_DATA 16'h0007
`define MOCS_ADDR_PULSE_DATA 16'h000A
`define MOCS_DATA_RESET 16'h0000

// Timing and scale
`define MOCS_CLK_HZ 40'd125000000
`define MOCS_RATE_UNIT 40'd100
`define MOCS_UPDATE_NS 1000000
`define MOCS_CLK_PERIOD_NS 8
`define MOCS_UPDATE_CYCLES (`MOCS_UPDATE_NS / `MOCS_CLK_PERIOD_NS)
`define MOCS_FULL_PCT 16'h2710
`define MOCS_FULL_MV 40'd100
`define MOCS_COMM_MV_PER_COUNT 20'h0000A
`define MOCS_PULSE_FULL_HZ 40'd144000
`define MOCS_PULSE_DATA_MAX 16'h3840

// Monitor output type
`define MOCS_TYPE_ANALOG 1'b0
`define MOCS_TYPE_PULSE 1'b1

// Analog sources
`define MOCS_SRC_FOUT 4'h0
`define MOCS_SRC_CURRENT 4'h1
`define MOCS_SRC_DCBUS 4'h2
`define MOCS_SRC_TORQUE 4'h3
`define MOCS_SRC_POWER 4'h4
`define MOCS_SRC_VREF 4'h5
`define MOCS_SRC_FREF 4'h6
`define MOCS_SRC_PID 4'h7
`define MOCS_SRC_COMM 4'h8

// Pulse scaling codes
`define MOCS_PULSE_FREF_BASE 6'h28
`define MOCS_PULSE_FREF_LAST 6'h2D
`define MOCS_PULSE_COMM 6'h32

// Carrier codes and fixed rates in 0.01 Hz
`define MOCS_CARRIER_2K5 4'h1
`define MOCS_CARRIER_5K0 4'h2
`define MOCS_CARRIER_7K5 4'h3
`define MOCS_CARRIER_10K 4'h4
`define MOCS_CARRIER_12F 4'h7
`define MOCS_CARRIER_24F 4'h8
`define MOCS_CARRIER_36F 4'h9
`define MOCS_CARRIER_14K 4'hC
`define MOCS_CARRIER_TRACK_BIAS 4'h4
`define MOCS_RATE_2K5 24'h03D090
`define MOCS_RATE_5K0 24'h07A120
`define MOCS_RATE_7K5 24'h0B71B0
`define MOCS_RATE_10K 24'h0F4240
`define MOCS_RATE_14K 24'h155CC0

// Reset and factory values
`define MOCS_GAIN_RESET 8'h64
`define MOCS_SRC_RESET 4'h0
`define MOCS_PULSE_RESET 6'h00
`define MOCS_CARRIER_RESET 4'h4
`define MOCS_CARRIER_LARGE 4'h3

`endif

// ### hw/mocs_div.v
`timescale 1ns/10ps
`default_nettype none
// Restoring divider, one quotient bit per clock
module mocs_div #(
	parameter W = 40
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Request
	input wire start,
	input wire [W-1:0] num,
	input wire [W-1:0] den,
	// Answer
	output reg busy,
	output reg done,
	output reg [W-1:0] quot
);
	reg [W-1:0] rem_reg;
	reg [W-1:0] den_reg;
	localparam [6:0] STEPS = W;
	reg [6:0] cnt_reg;
	wire [W:0] trial = {rem_reg[W-2:0], quot[W-1]} - {1'b0, den_reg};

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
			done <= 1'b0;
			quot <= {W{1'b0}};
			rem_reg <= {W{1'b0}};
			den_reg <= {W{1'b0}};
			cnt_reg <= 7'h00;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				busy <= 1'b1;
				quot <= num;
				rem_reg <= {W{1'b0}};
				den_reg <= den;
				cnt_reg <= STEPS;
			end else if (busy) begin
				if (trial[W]) begin
					rem_reg <= {rem_reg[W-2:0], quot[W-1]};
					quot <= {quot[W-2:0], 1'b0};
				end else begin
					rem_reg <= trial[W-1:0];
					quot <= {quot[W-2:0], 1'b1};
				end
				cnt_reg <= cnt_reg - 7'h01;
				if (cnt_reg == 7'h01) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### hw/mocs_sqgen.v
`timescale 1ns/10ps
`default_nettype none
// Square wave of even duty; a half period of zero stops it low
module mocs_sqgen #(
	parameter HW = 33
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Half period in clocks
	input wire [HW-1:0] half_period,
	// Wave
	output reg wave
);
	reg [HW-1:0] cnt_reg;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= {HW{1'b0}};
			wave <= 1'b0;
		end else if (half_period == {HW{1'b0}}) begin
			cnt_reg <= {HW{1'b0}};
			wave <= 1'b0;
		end else if (cnt_reg + {{(HW-1){1'b0}}, 1'b1} >= half_period) begin
			cnt_reg <= {HW{1'b0}};
			wave <= ~wave;
		end else begin
			cnt_reg <= cnt_reg + {{(HW-1){1'b0}}, 1'b1};
		end
	end
endmodule
`default_nettype wire

// ### hw/mocs_top.v
`timescale 1ns/10ps
`default_nettype none
`include "mocs_defs.vh"
module mocs_top #(
	parameter UPDATE_CYCLES = `MOCS_UPDATE_CYCLES
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Settings, loaded on set_wr
	input wire set_wr,
	input wire [3:0] analog_source_select,
	input wire monitor_output_type,
	input wire [1:0] monitor_output_type_raw_hi,
	input wire [7:0] analog_output_gain,
	input wire [5:0] pulse_scaling_select,
	input wire [3:0] carrier_select,
	input wire [15:0] max_output_frequency,
	input wire [15:0] reference_lower_limit,
	input wire [15:0] min_output_frequency,
	// Factory initialisation
	input wire factory_init,
	input wire capacity_large,
	// Drive quantities, frequencies in 0.01 Hz, others in 0.01 %
	input wire [15:0] output_frequency,
	input wire [15:0] output_current,
	input wire [15:0] dc_bus_voltage,
	input wire [15:0] torque,
	input wire [15:0] output_power,
	input wire [15:0] output_voltage_ref,
	input wire [15:0] frequency_reference,
	input wire [15:0] pid_feedback,
	// Start sequencing
	input wire run_cmd,
	input wire hold_cmd,
	output reg run_enable,
	output reg [15:0] run_frequency,
	// Host data words
	input wire host_wr,
	input wire host_rd,
	input wire [15:0] host_addr,
	input wire [15:0] host_wdata,
	output reg [15:0] host_rdata,
	// Monitor output terminals
	output reg [15:0] analog_mv,
	output reg monitor_pulse,
	// Carrier
	output reg carrier_out,
	output reg [3:0] carrier_code
);
	localparam S_IDLE = 5'b00001;
	localparam S_ANA = 5'b00010;
	localparam S_PRATE = 5'b00100;
	localparam S_PPER = 5'b01000;
	localparam S_CPER = 5'b10000;
	localparam [39:0] HALF_NUM = `MOCS_CLK_HZ * `MOCS_RATE_UNIT / 40'd2;

	// Multiplier for a scaling index; 0 means the 1440 Hz full-scale mode
	function [5:0] mult_of;
		input [2:0] idx;
		begin
			case (idx)
				3'h1: mult_of = 6'h01;
				3'h2: mult_of = 6'h06;
				3'h3: mult_of = 6'h0C;
				3'h4: mult_of = 6'h18;
				3'h5: mult_of = 6'h24;
				default: mult_of = 6'h00;
			endcase
		end
	endfunction

	// Index of a pulse scaling code within its group of six
	function [2:0] pulse_idx;
		input [5:0] code;
		begin
			case (code)
				6'h01: pulse_idx = 3'h1;
				6'h06: pulse_idx = 3'h2;
				6'h0C: pulse_idx = 3'h3;
				6'h18: pulse_idx = 3'h4;
				6'h24: pulse_idx = 3'h5;
				default: pulse_idx = 3'h0;
			endcase
		end
	endfunction

	reg [3:0] src_reg;
	reg type_reg;
	reg [7:0] gain_reg;
	reg [5:0] pscale_reg;
	reg [15:0] fmax_reg;
	reg [15:0] lower_reg;
	reg [15:0] fmin_reg;
	reg [15:0] adata_reg;
	reg [15:0] pdata_reg;
	reg run_d_reg;
	reg hold_start_reg;
	reg [31:0] tick_cnt_reg;
	reg [4:0] state_reg;
	reg div_start_reg;
	reg [39:0] div_num_reg;
	reg [39:0] div_den_reg;
	reg [32:0] phalf_reg;
	reg [32:0] chalf_reg;
	reg pulse_code_ok;
	reg [2:0] pidx;
	reg [15:0] pulse_base;
	reg [15:0] ana_q;
	reg [15:0] ana_fs;
	reg [23:0] carrier_rate;
	wire div_done;
	wire [39:0] div_quot;
	wire mon_wave;
	wire car_wave;
	wire carrier_code_ok = (carrier_select == `MOCS_CARRIER_2K5) || (carrier_select == `MOCS_CARRIER_5K0) ||
		(carrier_select == `MOCS_CARRIER_7K5) || (carrier_select == `MOCS_CARRIER_10K) ||
		(carrier_select == `MOCS_CARRIER_12F) || (carrier_select == `MOCS_CARRIER_24F) ||
		(carrier_select == `MOCS_CARRIER_36F) || (carrier_select == `MOCS_CARRIER_14K);
	wire tick = (tick_cnt_reg == UPDATE_CYCLES - 1);
	wire [15:0] pdata_cap = (pdata_reg > `MOCS_PULSE_DATA_MAX) ? `MOCS_PULSE_DATA_MAX : pdata_reg;
	wire [5:0] pfref_off = pscale_reg - `MOCS_PULSE_FREF_BASE;
	wire [19:0] comm_mv = adata_reg * `MOCS_COMM_MV_PER_COUNT;
	wire [3:0] car_off = carrier_code - `MOCS_CARRIER_TRACK_BIAS;

	// Pulse source and scaling decode
	always @* begin
		pulse_code_ok = 1'b1;
		pidx = 3'h0;
		pulse_base = output_frequency;
		if (pscale_reg >= `MOCS_PULSE_FREF_BASE && pscale_reg <= `MOCS_PULSE_FREF_LAST) begin
			pidx = pfref_off[2:0];
			pulse_base = frequency_reference;
		end else if (pscale_reg == `MOCS_PULSE_COMM) begin
			pulse_code_ok = 1'b1;
		end else begin
			pidx = pulse_idx(pscale_reg);
			pulse_code_ok = (pscale_reg == 6'h00) || (pidx != 3'h0);
		end
	end

	// Analog source mux
	always @* begin
		ana_fs = `MOCS_FULL_PCT;
		case (src_reg)
			`MOCS_SRC_FOUT: begin
				ana_q = output_frequency;
				ana_fs = fmax_reg;
			end
			`MOCS_SRC_CURRENT: ana_q = output_current;
			`MOCS_SRC_DCBUS: ana_q = dc_bus_voltage;
			`MOCS_SRC_TORQUE: ana_q = torque;
			`MOCS_SRC_POWER: ana_q = output_power;
			`MOCS_SRC_VREF: ana_q = output_voltage_ref;
			`MOCS_SRC_FREF: begin
				ana_q = frequency_reference;
				ana_fs = fmax_reg;
			end
			`MOCS_SRC_PID: begin
				ana_q = pid_feedback;
				ana_fs = fmax_reg;
			end
			`MOCS_SRC_COMM: ana_q = comm_mv[15:0];
			default: ana_q = 16'h0000;
		endcase
	end

	// Carrier rate in 0.01 Hz
	always @* begin
		case (carrier_code)
			`MOCS_CARRIER_2K5: carrier_rate = `MOCS_RATE_2K5;
			`MOCS_CARRIER_5K0: carrier_rate = `MOCS_RATE_5K0;
			`MOCS_CARRIER_7K5: carrier_rate = `MOCS_RATE_7K5;
			`MOCS_CARRIER_10K: carrier_rate = `MOCS_RATE_10K;
			`MOCS_CARRIER_14K: carrier_rate = `MOCS_RATE_14K;
			`MOCS_CARRIER_12F, `MOCS_CARRIER_24F, `MOCS_CARRIER_36F:
				carrier_rate = {8'h00, output_frequency} *
					{18'h00000, mult_of(car_off[2:0])};
			default: carrier_rate = 24'h000000;
		endcase
	end

	// Settings and host words
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			src_reg <= `MOCS_SRC_RESET;
			type_reg <= `MOCS_TYPE_ANALOG;
			gain_reg <= `MOCS_GAIN_RESET;
			pscale_reg <= `MOCS_PULSE_RESET;
			carrier_code <= `MOCS_CARRIER_RESET;
			fmax_reg <= 16'h0000;
			lower_reg <= 16'h0000;
			fmin_reg <= 16'h0000;
			adata_reg <= `MOCS_DATA_RESET;
			pdata_reg <= `MOCS_DATA_RESET;
			host_rdata <= 16'h0000;
		end else begin
			if (factory_init) begin
				type_reg <= `MOCS_TYPE_ANALOG;
				gain_reg <= `MOCS_GAIN_RESET;
				pscale_reg <= `MOCS_PULSE_RESET;
				src_reg <= `MOCS_SRC_RESET;
				carrier_code <= capacity_large ? `MOCS_CARRIER_LARGE : `MOCS_CARRIER_RESET;
			end else if (set_wr) begin
				if (analog_source_select <= `MOCS_SRC_COMM)
					src_reg <= analog_source_select;
				if (monitor_output_type_raw_hi == 2'b00)
					type_reg <= monitor_output_type;
				gain_reg <= analog_output_gain;
				pscale_reg <= pulse_scaling_select;
				if (carrier_code_ok)
					carrier_code <= carrier_select;
				fmax_reg <= max_output_frequency;
				lower_reg <= reference_lower_limit;
				fmin_reg <= min_output_frequency;
			end
			if (host_wr && host_addr == `MOCS_ADDR_ANALOG_DATA)
				adata_reg <= host_wdata;
			if (host_wr && host_addr == `MOCS_ADDR_PULSE_DATA)
				pdata_reg <= host_wdata;
			if (host_rd) begin
				if (host_addr == `MOCS_ADDR_ANALOG_DATA)
					host_rdata <= adata_reg;
				else if (host_addr == `MOCS_ADDR_PULSE_DATA)
					host_rdata <= pdata_reg;
				else
					host_rdata <= 16'h0000;
			end
		end
	end

	// Start with ramp hold
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run_d_reg <= 1'b0;
			hold_start_reg <= 1'b0;
			run_enable <= 1'b0;
			run_frequency <= 16'h0000;
		end else begin
			run_d_reg <= run_cmd;
			if (run_cmd && !run_d_reg)
				hold_start_reg <= hold_cmd;
			if (!run_cmd) begin
				run_enable <= 1'b0;
				run_frequency <= 16'h0000;
			end else if ((run_d_reg ? hold_start_reg : hold_cmd)) begin
				run_enable <= (lower_reg >= fmin_reg);
				run_frequency <= (lower_reg >= fmin_reg) ? lower_reg : 16'h0000;
			end else begin
				run_enable <= 1'b1;
				run_frequency <= frequency_reference;
			end
		end
	end

	// Update sequencer sharing one divider
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tick_cnt_reg <= 32'h00000000;
			state_reg <= S_IDLE;
			div_start_reg <= 1'b0;
			div_num_reg <= 40'h0000000000;
			div_den_reg <= 40'h0000000000;
			analog_mv <= 16'h0000;
			phalf_reg <= 33'h000000000;
			chalf_reg <= 33'h000000000;
		end else begin
			tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
			div_start_reg <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (tick) begin
						div_num_reg <= {8'h00, ana_q} * {32'h00000000, gain_reg} * `MOCS_FULL_MV;
						div_den_reg <= {24'h000000, ana_fs};
						div_start_reg <= 1'b1;
						state_reg <= S_ANA;
					end
				end
				S_ANA: begin
					if (div_done) begin
						if (type_reg == `MOCS_TYPE_ANALOG && ana_fs != 16'h0000)
							analog_mv <= (div_quot > 40'h000000FFFF) ? 16'hFFFF : div_quot[15:0];
						else
							analog_mv <= 16'h0000;
						if (type_reg != `MOCS_TYPE_PULSE || !pulse_code_ok) begin
							phalf_reg <= 33'h000000000;
							state_reg <= S_CPER;
							div_num_reg <= HALF_NUM;
							div_den_reg <= {16'h0000, carrier_rate};
							div_start_reg <= 1'b1;
						end else if (pscale_reg == `MOCS_PULSE_COMM) begin
							div_num_reg <= HALF_NUM;
							div_den_reg <= {24'h000000, pdata_cap} * `MOCS_RATE_UNIT;
							div_start_reg <= 1'b1;
							state_reg <= S_PPER;
						end else if (pidx == 3'h0) begin
							div_num_reg <= {24'h000000, pulse_base} * `MOCS_PULSE_FULL_HZ;
							div_den_reg <= {24'h000000, fmax_reg};
							div_start_reg <= 1'b1;
							state_reg <= S_PRATE;
						end else begin
							div_num_reg <= HALF_NUM;
							div_den_reg <= {24'h000000, pulse_base} * {34'h000000000, mult_of(pidx)};
							div_start_reg <= 1'b1;
							state_reg <= S_PPER;
						end
					end
				end
				S_PRATE: begin
					if (div_done) begin
						div_num_reg <= HALF_NUM;
						div_den_reg <= (fmax_reg == 16'h0000) ? 40'h0000000000 : div_quot;
						div_start_reg <= 1'b1;
						state_reg <= S_PPER;
					end
				end
				S_PPER: begin
					if (div_done) begin
						phalf_reg <= (div_den_reg == 40'h0000000000) ? 33'h000000000 : div_quot[32:0];
						div_num_reg <= HALF_NUM;
						div_den_reg <= {16'h0000, carrier_rate};
						div_start_reg <= 1'b1;
						state_reg <= S_CPER;
					end
				end
				S_CPER: begin
					if (div_done) begin
						chalf_reg <= (div_den_reg == 40'h0000000000) ? 33'h000000000 : div_quot[32:0];
						state_reg <= S_IDLE;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	mocs_div #(.W(40)) u_div (
		.clk(clk),
		.nrst(nrst),
		.start(div_start_reg),
		.num(div_num_reg),
		.den(div_den_reg),
		.busy(),
		.done(div_done),
		.quot(div_quot)
	);

	mocs_sqgen #(.HW(33)) u_mon (
		.clk(clk),
		.nrst(nrst),
		.half_period(phalf_reg),
		.wave(mon_wave)
	);

	mocs_sqgen #(.HW(33)) u_car (
		.clk(clk),
		.nrst(nrst),
		.half_period(chalf_reg),
		.wave(car_wave)
	);

	// Registered terminal drivers
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			monitor_pulse <= 1'b0;
			carrier_out <= 1'b0;
		end else begin
			monitor_pulse <= mon_wave;
			carrier_out <= car_wave;
		end
	end
endmodule
`default_nettype wire

// ### verification/mocs_meter.sv
`timescale 1ns/10ps
`default_nettype none
// Stands in for the external pulse counter: measures one high time after each restart
module mocs_meter (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Measured line and restart
	input wire logic sig,
	input wire logic clr,
	// Result in clocks
	output logic [31:0] hi,
	output logic fresh
);
	logic prev, armed;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev <= 1'b0;
			armed <= 1'b0;
			hi <= 32'h00000000;
			fresh <= 1'b0;
		end else begin
			prev <= sig;
			if (clr) begin
				armed <= 1'b0;
				fresh <= 1'b0;
			end else if (sig && !prev && !fresh) begin
				armed <= 1'b1;
				hi <= 32'h00000001;
			end else if (sig && armed && !fresh) begin
				hi <= hi + 32'h00000001;
			end else if (!sig && prev && armed) begin
				fresh <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### verification/mocs_top_props.sv
`timescale 1ns/10ps
`default_nettype none
module mocs_top_props #(
	parameter UPDATE_CYCLES = 200
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Settings
	input wire logic set_wr,
	input wire logic factory_init,
	input wire logic capacity_large,
	input wire logic monitor_output_type,
	input wire logic [1:0] monitor_output_type_raw_hi,
	input wire logic [3:0] carrier_select,
	input wire logic [15:0] reference_lower_limit,
	input wire logic [15:0] min_output_frequency,
	// Start sequencing
	input wire logic run_cmd,
	input wire logic hold_cmd,
	input wire logic run_enable,
	input wire logic [15:0] run_frequency,
	// Host words
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [15:0] host_addr,
	input wire logic [15:0] host_wdata,
	input wire logic [15:0] host_rdata,
	// Monitor and carrier
	input wire logic [15:0] analog_mv,
	input wire logic monitor_pulse,
	input wire logic [3:0] carrier_code
);
	logic [15:0] lo_q, mn_q, w7_q, wa_q;
	logic [3:0] car_q;
	logic typ_q;
	logic [31:0] calm_q;
	wire logic calm = calm_q >= 4 * UPDATE_CYCLES;
	wire logic addr_ok = host_addr == 16'h0007 || host_addr == 16'h000A;
	wire logic [15:0] sel_word = host_addr == 16'h0007 ? w7_q : wa_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Shadow of what the design should hold; calm counts cycles since the last setting load
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lo_q <= 16'h0000;
			mn_q <= 16'h0000;
			w7_q <= 16'h0000;
			wa_q <= 16'h0000;
			car_q <= 4'h4;
			typ_q <= 1'b0;
			calm_q <= 32'h00000000;
		end else begin
			calm_q <= (set_wr || factory_init) ? 32'h00000000 : calm ? calm_q : calm_q + 32'h00000001;
			if (set_wr && !factory_init) begin
				lo_q <= reference_lower_limit;
				mn_q <= min_output_frequency;
				if (monitor_output_type_raw_hi == 2'h0)
					typ_q <= monitor_output_type;
				if (carrier_select inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'hC})
					car_q <= carrier_select;
			end
			if (factory_init) begin
				typ_q <= 1'b0;
				car_q <= capacity_large ? 4'h3 : 4'h4;
			end
			if (host_wr && host_addr == 16'h0007)
				w7_q <= host_wdata;
			if (host_wr && host_addr == 16'h000A)
				wa_q <= host_wdata;
		end
	end
	chk_rd_unmapped: assert property (host_rd && !addr_ok |=> host_rdata == 16'h0000)
		else $error("unmapped read not zero");
	chk_rd_word: assert property (host_rd && !host_wr && addr_ok |=> host_rdata == $past(sel_word))
		else $error("host word read back wrong");
	chk_hold_block: assert property ($rose(run_cmd) && hold_cmd && lo_q < mn_q |=> !run_enable [*3])
		else $error("started under hold below minimum");
	chk_hold_lower: assert property ($rose(run_cmd) && hold_cmd && lo_q >= mn_q
		|=> run_enable && run_frequency == lo_q) else $error("hold start not at lower limit");
	chk_stop_idle: assert property (!run_cmd |=> !run_enable && run_frequency == 16'h0000)
		else $error("running without run command");
	chk_carrier_legal: assert property (carrier_code inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'hC})
		else $error("carrier code illegal");
	chk_carrier_follow: assert property (calm |-> carrier_code == car_q)
		else $error("carrier code not the selected one");
	chk_pulse_quiet: assert property (calm && !typ_q |-> !monitor_pulse)
		else $error("pulse in analog mode");
	chk_analog_quiet: assert property (calm && typ_q |-> analog_mv == 16'h0000)
		else $error("analog output in pulse mode");
	cover property ($rose(run_cmd) && hold_cmd);
	cover property (host_rd && addr_ok);
	cover property (calm && typ_q && $rose(monitor_pulse));
endmodule
bind mocs_top mocs_top_props #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_props (.clk, .nrst, .set_wr, .factory_init,
	.capacity_large, .monitor_output_type, .monitor_output_type_raw_hi, .carrier_select, .reference_lower_limit,
	.min_output_frequency, .run_cmd, .hold_cmd, .run_enable, .run_frequency, .host_wr, .host_rd, .host_addr,
	.host_wdata, .host_rdata, .analog_mv, .monitor_pulse, .carrier_code);
`default_nettype wire

// ### verification/test_monitor_output_carrier_select.sv
`timescale 1ns/10ps
`default_nettype none
module test_monitor_output_carrier_select;
	localparam int UPD = 200;
	logic clk = 1'b0, nrst = 1'b0, set_wr = 1'b0, factory_init = 1'b0, capacity_large = 1'b0, clr = 1'b0;
	logic monitor_output_type = 1'b0, run_cmd = 1'b0, hold_cmd = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
	logic [1:0] monitor_output_type_raw_hi = 2'h0;
	logic [3:0] analog_source_select = 4'h0, carrier_select = 4'h4;
	logic [5:0] pulse_scaling_select = 6'h00;
	logic [7:0] analog_output_gain = 8'h64;
	logic [15:0] max_output_frequency = 16'h9C40, reference_lower_limit = 16'h03E8, min_output_frequency = 16'h05DC;
	logic [15:0] host_addr = 16'h0000, host_wdata = 16'h0000, w7 = 16'h0000, da = 16'h0000;
	logic [15:0] q [0:7] = '{default: 16'h0000};
	logic [3:0] cset [0:7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'hC};
	wire logic run_enable, monitor_pulse, carrier_out, pf, cf;
	wire logic [15:0] run_frequency, host_rdata, analog_mv;
	wire logic [3:0] carrier_code;
	wire logic [31:0] ph, ch;
	int err_count = 0, checks = 0;
	mocs_top #(.UPDATE_CYCLES(UPD)) DUT (.clk, .nrst, .set_wr, .analog_source_select, .monitor_output_type,
		.monitor_output_type_raw_hi, .analog_output_gain, .pulse_scaling_select, .carrier_select,
		.max_output_frequency, .reference_lower_limit, .min_output_frequency, .factory_init, .capacity_large,
		.output_frequency(q[0]), .output_current(q[1]), .dc_bus_voltage(q[2]), .torque(q[3]),
		.output_power(q[4]), .output_voltage_ref(q[5]), .frequency_reference(q[6]), .pid_feedback(q[7]),
		.run_cmd, .hold_cmd, .run_enable, .run_frequency, .host_wr, .host_rd, .host_addr, .host_wdata,
		.host_rdata, .analog_mv, .monitor_pulse, .carrier_out, .carrier_code);
	mocs_meter pmeter (.clk, .nrst, .sig(monitor_pulse), .clr, .hi(ph), .fresh(pf));
	mocs_meter cmeter (.clk, .nrst, .sig(carrier_out), .clr, .hi(ch), .fresh(cf));
	always #4 clk = ~clk;
	task automatic complete_run;
		if (err_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input int tol);
		logic [31:0] d;
		d = seen > exp ? seen - exp : exp - seen;
		checks++;
		if (tol == 0 ? seen !== exp : ($isunknown(seen) || d > tol)) begin
			err_count++;
			$display("BAD %0t seen %0d want %0d", $time, seen, exp);
		end
	endtask
	// Load settings or factory values, then let two and a half update periods pass
	task automatic apply(input logic fac);
		set_wr <= !fac;
		factory_init <= fac;
		@(posedge clk) set_wr <= 1'b0;
		factory_init <= 1'b0;
		repeat (2 * UPD + 100) @(posedge clk);
	endtask
	task automatic host(input logic wr, input logic [15:0] a, input logic [15:0] d);
		host_wr <= wr;
		host_rd <= !wr;
		host_addr <= a;
		host_wdata <= d;
		@(posedge clk) host_wr <= 1'b0;
		host_rd <= 1'b0;
		@(posedge clk);
		if (!wr)
			check(host_rdata, d, 0);
	endtask
	task automatic meas(input logic [31:0] ep, input logic [31:0] ec);
		clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		@(posedge clk);
		for (int n = 0; n < 20000 && !(pf && cf); n++)
			@(posedge clk);
		check(pf & cf, 1, 0);
		check(ph, ep, 2);
		check(ch, ec, 2);
	endtask
	// Half period in clocks for a rate in 0.01 Hz
	function automatic logic [31:0] half(input longint rate);
		return 64'h174876E80 / rate;
	endfunction
	function automatic logic [31:0] emv(input int s);
		longint v, fs;
		fs = (s == 0 || s == 6 || s == 7) ? max_output_frequency : 64'h2710;
		v = (s == 8 ? 64'(w7) * 10 : 64'(q[s])) * analog_output_gain * 100 / fs;
		return v > 64'hFFFF ? 32'h0000FFFF : v[31:0];
	endfunction
	initial begin
		int r;
		r = $urandom(32'hBC9CFA54);
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		check(carrier_code, 4'h4, 0);
		host(1'b0, 16'h0007, 16'h0000);
		w7 = 16'($urandom_range(1000));
		da = 16'($urandom_range(14400, 10000));
		host(1'b1, 16'h0007, w7);
		host(1'b1, 16'h000A, da);
		host(1'b0, 16'h000A, da);
		host(1'b0, 16'h0007, w7);
		host(1'b1, 16'h0005, 16'hFFFF);
		host(1'b0, 16'h0005, 16'h0000);
		for (int s = 0; s < 9; s++) begin
			analog_source_select <= s[3:0];
			analog_output_gain <= s == 0 ? 8'h64 : 8'($urandom_range(255, 50));
			for (int i = 0; i < 8; i++)
				q[i] <= 16'($urandom_range(i == 0 || i > 5 ? 40000 : 10000));
			if (s == 0)
				q[0] <= max_output_frequency;
			apply(1'b0);
			check(analog_mv, emv(s), 1);
		end
		analog_source_select <= 4'h1;
		analog_output_gain <= 8'hFF;
		q[1] <= 16'hFFFF;
		apply(1'b0);
		check(analog_mv, 32'h0000FFFF, 0);
		analog_source_select <= 4'h9;
		monitor_output_type <= 1'b1;
		monitor_output_type_raw_hi <= 2'h2;
		apply(1'b0);
		check(analog_mv, 32'h0000FFFF, 0);
		monitor_output_type_raw_hi <= 2'h0;
		pulse_scaling_select <= 6'h32;
		// No serial traffic runs while the 14 kHz carrier is selected
		carrier_select <= 4'hC;
		apply(1'b0);
		check(analog_mv, 32'h00000000, 0);
		meas(half(64'(da) * 100), half(1400000));
		q[0] <= 16'h9C40;
		pulse_scaling_select <= 6'h24;
		carrier_select <= 4'h9;
		apply(1'b0);
		meas(half(1440000), half(1440000));
		q[0] <= 16'h4E20;
		q[6] <= 16'h9C40;
		pulse_scaling_select <= 6'h2D;
		carrier_select <= 4'h4;
		apply(1'b0);
		meas(half(1440000), half(1000000));
		// Full-scale mode with a low maximum so the pulse stays fast: 40x of 1440 Hz
		max_output_frequency <= 16'h03E8;
		q[0] <= 16'h9C40;
		pulse_scaling_select <= 6'h00;
		carrier_select <= 4'hC;
		apply(1'b0);
		meas(half(5760000), half(1400000));
		max_output_frequency <= 16'h9C40;
		for (int i = 0; i < 9; i++) begin
			carrier_select <= i == 8 ? 4'h5 : cset[i];
			apply(1'b0);
			check(carrier_code, i == 8 ? 4'hC : cset[i], 0);
		end
		for (int i = 0; i < 2; i++) begin
			capacity_large <= !i[0];
			apply(1'b1);
			check(carrier_code, i == 0 ? 4'h3 : 4'h4, 0);
		end
		analog_output_gain <= 8'h64;
		analog_source_select <= 4'h0;
		@(posedge clk);
		check(analog_mv, emv(0), 1);
		hold_cmd <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			if (i == 1)
				reference_lower_limit <= 16'h05DC;
			if (i == 2)
				hold_cmd <= 1'b0;
			apply(1'b0);
			run_cmd <= 1'b1;
			repeat (2) @(posedge clk);
			check(run_enable, i != 0, 0);
			check(run_frequency, i == 0 ? 16'h0000 : i == 1 ? 16'h05DC : q[6], 0);
			run_cmd <= 1'b0;
			@(posedge clk);
		end
		complete_run();
	end
	initial begin
		repeat (95000) @(posedge clk);
		err_count++;
		complete_run();
	end
endmodule
`default_nettype wire
